// ===== hdl/waveform_generator.v
// Notes on behaviour
// RL1 - Waveform drives only voltage or only current, as selected.
// RL2 - Remote control runs every function on the point engine.
// RL3 - Resistance mode blocks all access and arming; the code blocks writes and arming but still serves reads.
// RL4 - Samples are clamped to 52428 steps; slow ramps repeat values.
// RL5 - Point durations reach 36000 s; no minimum slope.
// RL6 - Unmodulated set values stay at their static values as limits.
// RL7 - Current is capped so power never passes the power set value.
// RL8 - Voltage waveform passes through unchanged; static U only limits.
// RL9 - Static U, I, P limits go out to slave units.
// RL10 - Selection and configuration only while the input is off.
// RL11 - Static set values apply before and after a run.
// RL12 - Arming the generator enables the input at static values.
// RL13 - Start by command, or by the button when input is off.
// RL14 - Command stop keeps input on; button stop turns it off.
// RL15 - Any alarm stops the run, disables input, and is reported.
// RL16 - Set values, amplitude, offset, frequency are live-writable.
// RL17 - Sine up to 10000 Hz; amplitude and offset share full scale.
// RL18 - Sine sample is offset plus amplitude times sine.
// RL19 - Triangle rises over rise time and falls over fall time.
// RL20 - Triangle starts at offset with amplitude on top.
// RL21 - Up to 99 points with AC, DC, frequency, angle, time.
// RL22 - Engine-start curve runs five voltage-only sequences.
// RL23 - Phase and timers advance once per internal tick; the code steps the timers once per 0.1 ms unit of ten ticks.
// RL24 - Every start begins from the waveform start point.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "wavegen_map.vh"

module udiv #(
  parameter W = 32,
  parameter CW = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [W-1:0] num_i,
  input wire [W-1:0] den_i,
  output reg busy_o,
  output reg [W-1:0] quo_o
);
  reg [W-1:0] rem_r;
  reg [W-1:0] q_r;
  reg [CW-1:0] cnt_r;
  wire [W:0] sh = {rem_r, q_r[W-1]};
  wire [W:0] df = sh - {1'b0, den_i};

  // Restoring divide; zero divisor gives all ones, a safe cap
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      quo_o <= {W{1'b0}};
      rem_r <= {W{1'b0}};
      q_r <= {W{1'b0}};
      cnt_r <= {CW{1'b0}};
    end
    else if (!busy_o)
    begin
      if (start_i)
      begin
        busy_o <= 1'b1;
        rem_r <= {W{1'b0}};
        q_r <= num_i;
        cnt_r <= W[CW-1:0];
      end
    end
    else
    begin
      rem_r <= df[W] ? sh[W-1:0] : df[W-1:0];
      q_r <= {q_r[W-2:0], ~df[W]};
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == 1)
      begin
        busy_o <= 1'b0;
        quo_o <= {q_r[W-2:0], ~df[W]};
      end
    end
  end
endmodule

module waveform_generator (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Device pins and measurement
  input wire remote_i,
  input wire resistance_regulation_mode_i,
  input wire onoff_btn_i,
  input wire [2:0] alarm_i,
  input wire [15:0] meas_u_i,
  // Set values, input enable and status flags to the regulation loop
  output reg [15:0] u_set_o,
  output reg [15:0] i_set_o,
  output reg [15:0] p_set_o,
  output reg input_en_o,
  output reg running_o,
  output reg alarm_o,
  // Limits for slave units
  output reg [15:0] ms_u_lim_o,
  output reg [15:0] ms_i_lim_o,
  output reg [15:0] ms_p_lim_o
);
  localparam S_IDLE = 4'b0001;
  localparam S_READY = 4'b0010;
  localparam S_LOAD = 4'b0100;
  localparam S_RUN = 4'b1000;

  reg [3:0] st_r;
  reg [3:0] st_nxt;
  reg en_r, alm_r, ref_r;
  reg [2:0] ctrl_r;
  reg [15:0] us_r, is_r, ps_r, amp_r, off_r, frq_r;
  reg [31:0] rise_r, fall_r;
  reg [6:0] npts_r;
  reg [9:0] ptadr_r;
  reg [31:0] mem [0:791];
  reg [5:0] s1_r, s2_r;
  reg btn_d_r, alm_d_r;
  reg [9:0] tick_r;
  reg [3:0] unit_r;
  reg [6:0] pt_r;
  reg [3:0] ld_r;
  reg dv_go_r, dv_wait_r;
  reg [15:0] dcs_r, dce_r, acs_r, ace_r, fs_r, fe_r;
  reg [8:0] ang_r;
  reg [31:0] tim_r, seg_r, s0_r, s1q_r, s2q_r;
  reg [31:0] dc_q, ac_q, f_q, ph_r;
  reg fall_ph_r;
  reg [15:0] mod_r;

  // Two-flop synchronisers for the button, mode, remote and alarm pins; meas_u_i is used unsynchronised
  wire btn_s = s2_r[5];
  wire rmod_s = s2_r[4];
  wire rem_s = s2_r[3];
  wire alm_s = |s2_r[2:0];
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      btn_d_r <= 1'b0;
      alm_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {onoff_btn_i, resistance_regulation_mode_i,
               remote_i, alarm_i};
      s2_r <= s1_r;
      btn_d_r <= btn_s;
      alm_d_r <= alm_s;
    end
  end
  wire btn_p = btn_s & ~btn_d_r;
  wire alm_p = alm_s & ~alm_d_r;

  // Effective function and target
  wire [1:0] fn_sel = ctrl_r[`C_FN_HI:`C_FN_LO];
  wire [1:0] fn = (rem_s && fn_sel != `FN_ENG) ? `FN_ARB
                  : fn_sel; // see RL2
  wire is_eng = (fn == `FN_ENG);
  wire is_pts = (fn == `FN_ARB) | is_eng;
  wire tgt_cur = ctrl_r[`C_TGT] & ~is_eng; // see RL1 see RL22
  wire [6:0] npts = is_eng ? `ENG_PTS : npts_r;

  // Register decode; live values stay writable during a run
  wire wr_ok = wr_i & ~rmod_s; // see RL3
  wire live = (addr_i >= `A_USET) && (addr_i <= `A_FREQ);
  wire cfg = (addr_i == `A_CTRL) || (addr_i >= `A_RISE &&
             addr_i <= `A_PTDAT);
  wire cfg_ok = wr_ok & cfg & ~en_r; // see RL10
  wire live_ok = wr_ok & live; // see RL16
  wire cmd_w = wr_ok && addr_i == `A_CMD;
  wire refuse = wr_i & ((rmod_s & (cfg | live)) | (cfg & en_r));

  // Amplitude and offset share the full scale
  wire [15:0] off_e = (off_r > `FULL) ? `FULL : off_r;
  wire [15:0] amp_e = (amp_r > `FULL - off_e) ? `FULL - off_e
                      : amp_r; // see RL17
  wire [15:0] frq_e = (frq_r > `FREQ_MAX) ? `FREQ_MAX : frq_r;

  // Tick and 0.1 ms unit dividers
  wire tick = (tick_r == `TICK_CYC - 1);
  wire unit = tick && (unit_r == `UNIT_TICKS - 1);
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_r <= 10'h000;
      unit_r <= 4'h0;
    end
    else
    begin
      tick_r <= tick ? 10'h000 : tick_r + 1'b1;
      if (tick)
        unit_r <= unit ? 4'h0 : unit_r + 1'b1;
    end
  end

  // Sequencer state
  wire run = (st_r == S_RUN);
  wire act = run | (st_r == S_LOAD);
  wire ld_done = (ld_r == 4'hB);
  wire seg_end = unit && (seg_r + 1'b1 >= tim_r);
  wire last_pt = (pt_r + 1'b1 >= npts);
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE:
        if (cmd_w && wdata_i[`K_ARM])
          st_nxt = S_READY; // see RL12
      S_READY:
        if (cmd_w && wdata_i[`K_START])
          st_nxt = S_LOAD; // see RL13
        else if (btn_p && !en_r)
          st_nxt = S_LOAD; // see RL13
        else if (cmd_w && wdata_i[`K_DISARM])
          st_nxt = S_IDLE;
      S_LOAD:
        if (ld_done)
          st_nxt = S_RUN;
      S_RUN:
        if (is_pts && seg_end)
          st_nxt = last_pt ? S_READY : S_LOAD;
      default:
        st_nxt = S_IDLE;
    endcase
    if (act && ((cmd_w && wdata_i[`K_STOP]) || btn_p))
      st_nxt = S_READY; // see RL14
    if (act && alm_p)
      st_nxt = S_READY; // see RL15
    if (rmod_s)
      st_nxt = S_IDLE; // see RL3
  end

  // State, input enable, sticky flags (setting wins over clearing)
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= S_IDLE;
      en_r <= 1'b0;
      alm_r <= 1'b0;
      ref_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == S_IDLE && st_nxt == S_READY)
        en_r <= 1'b1; // see RL12
      else if (st_r == S_READY && st_nxt == S_LOAD)
        en_r <= 1'b1;
      else if (btn_p && st_r != S_READY)
        en_r <= (st_r == S_IDLE) ? ~en_r : 1'b0; // see RL14
      else if (btn_p && en_r)
        en_r <= 1'b0;
      if (alm_s)
        en_r <= 1'b0; // see RL15
      if (alm_p)
        alm_r <= 1'b1; // see RL15
      else if (wr_ok && addr_i == `A_STAT && wdata_i[`S_ALM])
        alm_r <= 1'b0;
      if (refuse)
        ref_r <= 1'b1;
      else if (wr_ok && addr_i == `A_STAT && wdata_i[`S_REF])
        ref_r <= 1'b0;
    end
  end

  // Register file writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= 3'h0;
      us_r <= 16'h0000;
      is_r <= 16'h0000;
      ps_r <= 16'h0000;
      amp_r <= 16'h0000;
      off_r <= 16'h0000;
      frq_r <= 16'h0000;
      rise_r <= `RST_TIME;
      fall_r <= `RST_TIME;
      npts_r <= `RST_NPTS;
      ptadr_r <= 10'h000;
    end
    else
    begin
      if (live_ok)
        case (addr_i)
          `A_USET: us_r <= wdata_i[15:0];
          `A_ISET: is_r <= wdata_i[15:0];
          `A_PSET: ps_r <= wdata_i[15:0];
          `A_AMP: amp_r <= wdata_i[15:0];
          `A_OFFS: off_r <= wdata_i[15:0];
          default: frq_r <= wdata_i[15:0];
        endcase
      if (cfg_ok)
        case (addr_i)
          `A_CTRL: ctrl_r <= wdata_i[2:0];
          `A_RISE: rise_r <= wdata_i;
          `A_FALL: fall_r <= wdata_i;
          `A_NPTS: npts_r <= (wdata_i > {25'h0, `NPTS_MAX}) ?
                   `NPTS_MAX : wdata_i[6:0]; // see RL21
          `A_PTADR: ptadr_r <= wdata_i[9:0];
          `A_PTDAT: ptadr_r <= (ptadr_r == `MEM_WORDS - 1) ?
                    10'h000 : ptadr_r + 1'b1;
          default: ptadr_r <= ptadr_r;
        endcase
    end
  end

  // Point table: eight words per point, no reset needed
  always @(posedge clk_i)
  begin
    if (cfg_ok && addr_i == `A_PTDAT)
      mem[ptadr_r] <= wdata_i; // see RL2 see RL21
  end

  // Divider operands per load stage
  wire [31:0] pw = mem[{pt_r, ld_r[2:0]}];
  wire [15:0] ddc = (dce_r > dcs_r) ? dce_r - dcs_r : dcs_r - dce_r;
  wire [15:0] dac = (ace_r > acs_r) ? ace_r - acs_r : acs_r - ace_r;
  wire [15:0] dfr = (fe_r > fs_r) ? fe_r - fs_r : fs_r - fe_r;
  reg [15:0] dv_n;
  reg [31:0] dv_d;
  always @*
  begin
    dv_n = is_pts ? ddc : amp_e;
    dv_d = is_pts ? tim_r : rise_r;
    if (ld_r == 4'h9)
    begin
      dv_n = is_pts ? dac : amp_e;
      dv_d = is_pts ? tim_r : fall_r;
    end
    else if (ld_r == 4'hA)
    begin
      dv_n = dfr;
      dv_d = tim_r;
    end
  end
  wire dv_busy;
  wire [31:0] dv_q;
  udiv #(.W(32), .CW(6)) u_slope (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(dv_go_r),
    .num_i({dv_n, 16'h0000}),
    .den_i(dv_d),
    .busy_o(dv_busy),
    .quo_o(dv_q)
  );

  // Power cap on current: i_max = P * 2^16 / U
  wire pc_busy;
  wire [31:0] pc_q;
  udiv #(.W(32), .CW(6)) u_pcap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(~pc_busy),
    .num_i({ps_r, 16'h0000}),
    .den_i({16'h0000, meas_u_i}),
    .busy_o(pc_busy),
    .quo_o(pc_q)
  );
  wire [15:0] icap = (|pc_q[31:16]) ? 16'hFFFF : pc_q[15:0];

  // Quarter-wave sine table, Q15
  function [14:0] sinq;
    input [3:0] i;
    case (i)
      4'h0: sinq = 15'h0648;
      4'h1: sinq = 15'h12C8;
      4'h2: sinq = 15'h1F1A;
      4'h3: sinq = 15'h2B1F;
      4'h4: sinq = 15'h36BA;
      4'h5: sinq = 15'h41CE;
      4'h6: sinq = 15'h4C3F;
      4'h7: sinq = 15'h55F5;
      4'h8: sinq = 15'h5ED7;
      4'h9: sinq = 15'h66CF;
      4'hA: sinq = 15'h6DC9;
      4'hB: sinq = 15'h73B5;
      4'hC: sinq = 15'h7884;
      4'hD: sinq = 15'h7C29;
      4'hE: sinq = 15'h7E9C;
      default: sinq = 15'h7FD8;
    endcase
  endfunction
  wire [3:0] qi = ph_r[30] ? ~ph_r[29:26] : ph_r[29:26];
  wire [15:0] sv = {1'b0, sinq(qi)};
  wire signed [15:0] sn = ph_r[31] ? -sv : sv;

  // Sample: base plus amplitude times sine, clamped to full scale
  wire [15:0] base = (fn == `FN_SINE) ? off_e
                     : (fn == `FN_TRI) ? off_e + dc_q[31:16]
                     : dc_q[31:16]; // see RL20
  wire [15:0] ampv = (fn == `FN_SINE) ? amp_e
                     : (fn == `FN_TRI || is_eng) ? 16'h0000
                     : ac_q[31:16];
  wire signed [32:0] pr = $signed({1'b0, ampv}) * sn; // see RL18
  wire signed [18:0] smp = $signed({3'b000, base}) +
                           {pr[32], pr[32:15]};
  wire [15:0] smp_c = smp[18] ? 16'h0000
                      : (smp[17:0] > {2'b00, `FULL}) ? `FULL
                      : smp[15:0]; // see RL4
  wire [31:0] fhz = {16'h0000, (fn == `FN_SINE) ? frq_e
                     : f_q[31:16]};
  wire [31:0] pinc = fhz * {16'h0000, `PH_PER_HZ};

  // Point fetch, slope division and waveform engine
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pt_r <= 7'h00;
      ld_r <= 4'h0;
      dv_go_r <= 1'b0;
      dv_wait_r <= 1'b0;
      {dcs_r, dce_r, acs_r, ace_r, fs_r, fe_r} <= 96'h0;
      ang_r <= 9'h000;
      tim_r <= `RST_TIME;
      {seg_r, s0_r, s1q_r, s2q_r} <= 128'h0;
      {dc_q, ac_q, f_q, ph_r} <= 128'h0;
      fall_ph_r <= 1'b0;
      mod_r <= 16'h0000;
    end
    else
    begin
      dv_go_r <= 1'b0;
      if (!act)
      begin
        pt_r <= 7'h00; // see RL24
        ld_r <= 4'h0;
        dv_wait_r <= 1'b0;
        ph_r <= 32'h0000_0000;
        dc_q <= 32'h0000_0000;
        fall_ph_r <= 1'b0;
        seg_r <= 32'h0000_0000;
        tim_r <= rise_r;
      end
      else if (st_r == S_LOAD)
      begin
        if (ld_r < 4'h8)
        begin
          ld_r <= is_pts ? ld_r + 1'b1 : 4'h8;
          case (ld_r[2:0])
            3'h0: acs_r <= is_eng ? 16'h0000 : pw[15:0];
            3'h1: ace_r <= is_eng ? 16'h0000 : pw[15:0];
            3'h2: dcs_r <= pw[15:0];
            3'h3: dce_r <= pw[15:0];
            3'h4: fs_r <= is_eng ? 16'h0000 : pw[15:0];
            3'h5: fe_r <= is_eng ? 16'h0000 : pw[15:0];
            3'h6: ang_r <= pw[8:0];
            default: tim_r <= (pw > `TIME_MAX) ? `TIME_MAX
                     : (pw == 0) ? 32'h0000_0001 : pw; // see RL5
          endcase
        end
        else if (!dv_busy && !dv_wait_r)
        begin
          dv_go_r <= 1'b1;
          dv_wait_r <= 1'b1;
        end
        else if (!dv_busy && dv_wait_r && !dv_go_r)
        begin
          dv_wait_r <= 1'b0;
          ld_r <= ld_r + 1'b1;
          if (ld_r == 4'h8)
            s0_r <= dv_q;
          else if (ld_r == 4'h9)
            s1q_r <= dv_q;
          else
          begin
            s2q_r <= dv_q;
            seg_r <= 32'h0000_0000;
            if (is_pts)
            begin
              dc_q <= {dcs_r, 16'h0000};
              ac_q <= {acs_r, 16'h0000};
              f_q <= {fs_r, 16'h0000};
              ph_r <= ang_r * `DEG_PH;
            end
            else
              tim_r <= rise_r;
          end
        end
      end
      else if (run && tick)
      begin
        ph_r <= ph_r + pinc; // see RL23
        mod_r <= smp_c;
        if (unit && fn == `FN_TRI)
        begin
          seg_r <= seg_end ? 32'h0000_0000 : seg_r + 1'b1;
          if (seg_end)
          begin
            fall_ph_r <= ~fall_ph_r;
            dc_q <= fall_ph_r ? 32'h0000_0000
                    : {amp_e, 16'h0000}; // see RL19
            tim_r <= fall_ph_r ? rise_r : fall_r;
          end
          else
            dc_q <= fall_ph_r ? dc_q - s1q_r : dc_q + s0_r;
        end
        else if (unit && is_pts)
        begin
          seg_r <= seg_r + 1'b1;
          dc_q <= (dce_r > dcs_r) ? dc_q + s0_r : dc_q - s0_r;
          ac_q <= (ace_r > acs_r) ? ac_q + s1q_r : ac_q - s1q_r;
          f_q <= (fe_r > fs_r) ? f_q + s2q_r : f_q - s2q_r;
          if (seg_end)
          begin
            pt_r <= pt_r + 1'b1;
            ld_r <= 4'h0;
          end
        end
      end
    end
  end

  // Outputs to the loop: static values unless this one is modulated; current also capped by icap
  wire [15:0] i_c = (run && tgt_cur) ? mod_r : is_r; // see RL6
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      u_set_o <= 16'h0000;
      i_set_o <= 16'h0000;
      p_set_o <= 16'h0000;
      input_en_o <= 1'b0;
      running_o <= 1'b0;
      alarm_o <= 1'b0;
      ms_u_lim_o <= 16'h0000;
      ms_i_lim_o <= 16'h0000;
      ms_p_lim_o <= 16'h0000;
    end
    else
    begin
      u_set_o <= (run && !tgt_cur) ? mod_r : us_r; // see RL8 see RL11
      i_set_o <= (i_c > icap) ? icap : i_c; // see RL7
      p_set_o <= ps_r; // see RL6
      input_en_o <= en_r;
      running_o <= run;
      alarm_o <= alm_r;
      ms_u_lim_o <= us_r; // see RL9
      ms_i_lim_o <= is_r;
      ms_p_lim_o <= ps_r;
    end
  end

  // Read port: data valid in the cycle after the strobe only
  always @(posedge clk_i)
  begin
    if (rst_i || !rd_i)
      rdata_o <= 32'h0000_0000;
    else
      case (addr_i)
        `A_CTRL: rdata_o <= {29'h0, ctrl_r};
        `A_STAT: rdata_o <= {24'h0, rmod_s, ref_r, alm_r, en_r,
                            st_r};
        `A_USET: rdata_o <= {16'h0, us_r};
        `A_ISET: rdata_o <= {16'h0, is_r};
        `A_PSET: rdata_o <= {16'h0, ps_r};
        `A_AMP: rdata_o <= {16'h0, amp_r};
        `A_OFFS: rdata_o <= {16'h0, off_r};
        `A_FREQ: rdata_o <= {16'h0, frq_r};
        `A_RISE: rdata_o <= rise_r;
        `A_FALL: rdata_o <= fall_r;
        `A_NPTS: rdata_o <= {25'h0, npts_r};
        `A_PTADR: rdata_o <= {22'h0, ptadr_r};
        `A_PTDAT: rdata_o <= mem[ptadr_r];
        `A_OUTU: rdata_o <= {16'h0, u_set_o};
        `A_OUTI: rdata_o <= {16'h0, i_set_o};
        default: rdata_o <= 32'h0000_0000;
      endcase
  end
endmodule

// ===== hdl/wavegen_map.vh
`ifndef WAVEGEN_MAP_VH
`define WAVEGEN_MAP_VH
// Register word indexes
`define A_CTRL 8'h00
`define A_CMD 8'h01
`define A_STAT 8'h02
`define A_USET 8'h03
`define A_ISET 8'h04
`define A_PSET 8'h05
`define A_AMP 8'h06
`define A_OFFS 8'h07
`define A_FREQ 8'h08
`define A_RISE 8'h09
`define A_FALL 8'h0A
`define A_NPTS 8'h0B
`define A_PTADR 8'h0C
`define A_PTDAT 8'h0D
`define A_OUTU 8'h0E
`define A_OUTI 8'h0F
// Control fields
`define C_TGT 0
`define C_FN_HI 2
`define C_FN_LO 1
// Command bits
`define K_ARM 0
`define K_START 1
`define K_STOP 2
`define K_DISARM 3
// Status bits above the state code
`define S_EN 4
`define S_ALM 5
`define S_REF 6
`define S_RMOD 7
// Function codes
`define FN_SINE 2'h0
`define FN_TRI 2'h1
`define FN_ARB 2'h2
`define FN_ENG 2'h3
// Amplitude and table limits
`define FULL 16'hCCCC
`define FREQ_MAX 16'h2710
`define NPTS_MAX 7'h63
`define ENG_PTS 7'h05
`define MEM_WORDS 10'h318
`define TIME_MAX 32'h1575_2A00
// Phase steps per Hz at the tick rate and per degree
`define PH_PER_HZ 16'hA7C6
`define DEG_PH 24'hB6_0B61
// Timing
`define CLK_HZ 32'h05F5_E100
`define TICK_HZ 32'h0001_86A0
`define NS_PER_S 32'h3B9A_CA00
`define UNIT_NS 32'h0001_86A0
`define TICK_CYC (`CLK_HZ / `TICK_HZ)
`define UNIT_TICKS (`UNIT_NS / (`NS_PER_S / `TICK_HZ))
// Reset values
`define RST_NPTS 7'h01
`define RST_TIME 32'h0000_000A
`endif

// ===== tb/regulation_loop_model.sv
`timescale 1ns/100ps
// Regulation loop with a stiff source that the load can only pull down
module regulation_loop_model #(
  parameter [15:0] V_SRC = 16'h4000
) (
  input wire clk_i,
  input wire [15:0] u_set_i,
  input wire input_en_i,
  output logic [15:0] meas_u_o
);
  initial meas_u_o = V_SRC;
  // A voltage set value above the source has no effect
  always @(posedge clk_i)
  begin
    if (input_en_i && u_set_i < V_SRC)
      meas_u_o <= u_set_i;
    else
      meas_u_o <= V_SRC;
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "wavegen_map.vh"
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk_i, rst_i, wr_i, rd_i, rmode, btn, remote;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [2:0] alarm_i;
  logic [15:0] meas_u, u_set_o, i_set_o;
  logic input_en_o, running_o, alarm_o;
  int err_count = 0;
  int cmp_count = 0;
  // Address, data written, value read back
  row_t rows [0:8] = '{
    '{`A_USET, 32'h0000_CCCC, 32'h0000_CCCC},
    '{`A_ISET, 32'h0000_2000, 32'h0000_2000},
    '{`A_PSET, 32'h0000_1000, 32'h0000_1000},
    '{`A_OFFS, 32'h0000_6000, 32'h0000_6000},
    '{`A_AMP, 32'h0000_0000, 32'h0000_0000},
    '{`A_FREQ, 32'h0000_4E20, 32'h0000_4E20},
    '{`A_NPTS, 32'h0000_00C8, 32'h0000_0063},
    '{`A_PTADR, 32'h0000_0317, 32'h0000_0317},
    '{`A_CTRL, 32'h0000_0001, 32'h0000_0001}};
  // One point: flat DC level 0x1000 for two 0.1 ms units, no AC part
  logic [15:0] pt [0:7] = '{16'h0000, 16'h0000, 16'h1000, 16'h1000,
    16'h0000, 16'h0000, 16'h0000, 16'h0002};

  waveform_generator waveform_generator_i (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .remote_i(remote),
    .resistance_regulation_mode_i(rmode), .onoff_btn_i(btn),
    .alarm_i(alarm_i), .meas_u_i(meas_u), .u_set_o(u_set_o),
    .i_set_o(i_set_o), .p_set_o(), .input_en_o(input_en_o),
    .running_o(running_o), .alarm_o(alarm_o), .ms_u_lim_o(),
    .ms_i_lim_o(), .ms_p_lim_o());
  regulation_loop_model regulation_loop_model_i (.clk_i(clk_i),
    .u_set_i(u_set_o), .input_en_i(input_en_o), .meas_u_o(meas_u));

  initial clk_i = 1'b0;
  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic stop_test;
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      $display("mismatch %s exp %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Strobes drop one edge later, so a following access leaves a gap
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask
  // Button held long enough to pass the input synchroniser
  task automatic press;
    btn <= 1'b1;
    cycles(4);
    btn <= 1'b0;
    cycles(4);
  endtask
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (running_o !== v && n < 25000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("running", running_o, v);
  endtask

  // Watchdog: the sequence needs well under 40000 cycles
  initial
  begin
    #600_000;
    err_count++;
    stop_test;
  end

  initial
  begin
    {wr_i, rd_i, rmode, btn, remote, addr_i, wdata_i, alarm_i} = '0;
    rst_i = 1'b1;
    cycles(6);
    rst_i <= 1'b0;
    #1 chk("outputs", {running_o, input_en_o, alarm_o}, 3'b000);
    rchk(`A_STAT, 32'h0000_0001, "stat reset");
    rchk(`A_RISE, 32'h0000_000A, "rise reset");
    foreach (rows[k])
    begin
      wr(rows[k].a, rows[k].d);
      rchk(rows[k].a, rows[k].e, "row");
    end
    wr(8'h20, 32'h0000_5555);
    rchk(`A_USET, 32'h0000_CCCC, "unmapped");
    wr(`A_PTDAT, 32'h0000_0123);
    rchk(`A_PTADR, 32'h0000_0000, "point wrap");
    // Arm: input on at static values, configuration locked
    wr(`A_CMD, 32'h0000_0001);
    cycles(100);
    chk("armed input", input_en_o, 1'b1);
    chk("static i", i_set_o, 16'h2000);
    wr(`A_CTRL, 32'h0000_0002);
    rchk(`A_STAT, 32'h0000_0052, "refused");
    rchk(`A_CTRL, 32'h0000_0001, "ctrl kept");
    wr(`A_STAT, 32'h0000_0040);
    // Current sine of 0x6000 capped by power 0x1000 at 0x4000 volts
    wr(`A_CMD, 32'h0000_0002);
    wait_run(1'b1);
    cycles(2500);
    chk("power cap", i_set_o, 16'h4000);
    chk("u static", u_set_o, 16'hCCCC);
    wr(`A_PSET, 32'h0000_0C00);
    cycles(200);
    chk("live pset", i_set_o, 16'h3000);
    chk("still run", running_o, 1'b1);
    wr(`A_CMD, 32'h0000_0004);
    wait_run(1'b0);
    wr(`A_PSET, 32'h0000_1000);
    cycles(200);
    chk("stop input", input_en_o, 1'b1);
    chk("after run i", i_set_o, 16'h2000);
    // Button: off, then start from off, then stop with input off
    press;
    chk("btn off", input_en_o, 1'b0);
    press;
    wait_run(1'b1);
    press;
    wait_run(1'b0);
    chk("btn stop", input_en_o, 1'b0);
    // Alarm in mid-run
    wr(`A_CMD, 32'h0000_0002);
    wait_run(1'b1);
    alarm_i <= 3'b010;
    cycles(10);
    chk("alarm run", {running_o, input_en_o, alarm_o}, 3'b001);
    rchk(`A_STAT, 32'h0000_0022, "alarm stat");
    alarm_i <= 3'b000;
    wr(`A_STAT, 32'h0000_0020);
    wr(`A_CMD, 32'h0000_0008);
    rchk(`A_STAT, 32'h0000_0001, "disarm");
    // Remote: a sine selection runs as one voltage point; the table
    // pointer already wrapped to word 0
    remote <= 1'b1;
    wr(`A_CTRL, 32'h0000_0000);
    wr(`A_NPTS, 32'h0000_0001);
    foreach (pt[k]) wr(`A_PTDAT, {16'h0000, pt[k]});
    wr(`A_CMD, 32'h0000_0001);
    wr(`A_CMD, 32'h0000_0002);
    wait_run(1'b1);
    cycles(1500);
    chk("point u", u_set_o, 16'h1000);
    wait_run(1'b0);
    chk("point end en", input_en_o, 1'b1);
    chk("point end u", u_set_o, 16'hCCCC);
    press;
    remote <= 1'b0;
    wr(`A_CMD, 32'h0000_0008);
    // Resistance mode refuses writes and commands
    rmode <= 1'b1;
    cycles(5);
    wr(`A_USET, 32'h0000_1111);
    wr(`A_CMD, 32'h0000_0001);
    rchk(`A_STAT, 32'h0000_00C1, "rmode stat");
    rchk(`A_USET, 32'h0000_CCCC, "rmode uset");
    rmode <= 1'b0;
    cycles(5);
    stop_test;
  end
endmodule

// ===== tb/waveform_generator_props.sv
`timescale 1ns/100ps
module waveform_generator_props (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire resistance_regulation_mode_i,
  input wire [2:0] alarm_i,
  input wire [15:0] u_set_o,
  input wire [15:0] i_set_o,
  input wire [15:0] p_set_o,
  input wire input_en_o,
  input wire running_o,
  input wire alarm_o,
  input wire [15:0] ms_u_lim_o,
  input wire [15:0] ms_i_lim_o,
  input wire [15:0] ms_p_lim_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_lasts: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data stood past its cycle");
  a_limit_copy: assert property (
    (!resistance_regulation_mode_i)[*4] ##0 (wr_i && addr_i == 8'h05)
    |-> ##2 ms_p_lim_o == $past(wdata_i[15:0], 2))
    else $error("slave power limit not forwarded");
  a_rmode_idle: assert property (
    resistance_regulation_mode_i[*5] |-> !running_o)
    else $error("run while resistance mode held");
  a_alarm_halt: assert property (
    (alarm_i != 3'h0 && !wr_i)[*5] |-> alarm_o && !input_en_o && !running_o)
    else $error("alarm did not halt the run");
  a_pset_out: assert property (
    (!resistance_regulation_mode_i)[*4] ##0 (wr_i && addr_i == 8'h05)
    |-> ##2 p_set_o == $past(wdata_i[15:0], 2))
    else $error("power set value not applied");
  a_u_static: assert property (
    (!running_o && $stable(ms_u_lim_o))[*4] |-> u_set_o == ms_u_lim_o)
    else $error("static voltage not applied");
  a_i_bound: assert property (
    (!running_o && $stable(ms_i_lim_o))[*4] |-> i_set_o <= ms_i_lim_o)
    else $error("current above static set value");
  a_sample_max: assert property (
    running_o[*3] |-> u_set_o <= 16'hCCCC || u_set_o == ms_u_lim_o)
    else $error("voltage sample beyond full scale");
  a_stop_cmd: assert property (
    running_o && wr_i && addr_i == 8'h01 && wdata_i == 32'h0000_0004
    |-> ##[1:3] (!running_o && input_en_o))
    else $error("stop command misbehaved");
endmodule

bind waveform_generator waveform_generator_props props_i (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .resistance_regulation_mode_i(resistance_regulation_mode_i),
  .alarm_i(alarm_i), .u_set_o(u_set_o), .i_set_o(i_set_o),
  .p_set_o(p_set_o), .input_en_o(input_en_o), .running_o(running_o),
  .alarm_o(alarm_o), .ms_u_lim_o(ms_u_lim_o), .ms_i_lim_o(ms_i_lim_o),
  .ms_p_lim_o(ms_p_lim_o)
);
